/* File: verilog/zone_response_defines.vh */
// Constants for the zone response evaluator: response type codes, arming
// mode bit positions and fixed sizes.
// Assumes inclusion by bare name from the design files.
`ifndef ZONE_RESPONSE_DEFINES_VH
`define ZONE_RESPONSE_DEFINES_VH

// ------------------------------------------------------------------
// Zone response type codes (4-bit field per zone)
// ------------------------------------------------------------------
`define ZT_UNUSED      4'h0
`define ZT_ENTRY_EXIT1 4'h1
`define ZT_ENTRY_EXIT2 4'h2
`define ZT_PERIMETER   4'h3
`define ZT_FOLLOWER    4'h4
`define ZT_DAY_NIGHT   4'h5
`define ZT_SILENT_24   4'h6
`define ZT_AUDIBLE_24  4'h7
`define ZT_AUX_24      4'h8
`define ZT_FIRE        4'h9
`define ZT_WIDTH       4

// ------------------------------------------------------------------
// Arming state one-hot bit positions
// ------------------------------------------------------------------
`define ARM_DISARMED   0
`define ARM_FULL_DLY   1
`define ARM_PERIM_DLY  2
`define ARM_PERIM_NODLY 3
`define ARM_FULL_NODLY 4
`define ARM_WIDTH      5

// ------------------------------------------------------------------
// Sizes and timing
// ------------------------------------------------------------------
`define DELAY_WIDTH    16
`define ZONE_COUNT     8
`define PANIC_PER_PART 3
`define PART_COUNT     2
`define RF_SUPV_COUNT  4
`define FIRE_PULSE_NS  500000000
`define CLK_PERIOD_NS  4

`endif

/* File: verilog/zone_delay_timer.v */
// Entry/exit delay down-counter for one delay class (primary or secondary).
// Assumes load and abort come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "zone_response_defines.vh"

module zone_delay_timer #(
   parameter W = `DELAY_WIDTH
) (
   input wire clk,
   input wire rst,
   input wire load,
   input wire abort,
   input wire [W-1:0] duration,
   output reg running,
   output reg expired
);

   reg [W-1:0] count;

   // Load from the programmed duration, count to zero, pulse on expiry
   always @(posedge clk) begin
      if (rst) begin
         count <= {W{1'b0}};
         running <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (abort) begin
            running <= 1'b0;
         end else if (load && !running) begin
            count <= duration;
            running <= 1'b1;
         end else if (running) begin
            if (count == {W{1'b0}}) begin
               running <= 1'b0;
               expired <= 1'b1;
            end else begin
               count <= count - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule
`default_nettype wire

/* File: verilog/zone_response_evaluator.v */
// Per-zone alarm response evaluation for one intrusion panel.
// Assumes fault/short/open pins are asynchronous; arming, types and delays
// come from logic on clk.
//
// How it works
// - Type 0 zones produce nothing in any arming state.
// - Type 1 fault starts primary entry delay only in delayed arming modes.
// - Every arming event starts the primary exit delay for type 1 zones.
// - Type 2 fault starts secondary entry delay only in delayed modes.
// - Every arming event starts the secondary exit delay, own duration.
// - Type 3 fault alarms instantly in any armed mode.
// - Type 4 alarms after entry delay if entry zone faulted first.
// - Type 4 active in full modes; no-delay full mode alarms at once.
// - Type 4 with perimeter_arm_with_delays flag is bypassed in perimeter modes.
// - Type 5 alarms when armed; latches keypad trouble when disarmed.
// - Type 6 always active; report only, no keypad or sounder.
// - Type 7 always active; report, keypad sounder and external bell.
// - Type 8 always active; report and keypad only.
// - Type 9 short gives fire alarm, open gives trouble, no verify.
// - Type 9 always active, ignores bypass, bell pulses on fire.
// - Three panic zones per partition plus polling supervision zone.
// - Four RF supervisory zones, each with programmed type.
`timescale 1ns/10ps
`default_nettype none
`include "zone_response_defines.vh"

module zone_response_evaluator #(
   parameter NZ = `ZONE_COUNT + `PANIC_PER_PART * `PART_COUNT + 1 + `RF_SUPV_COUNT,
   parameter DW = `DELAY_WIDTH,
   parameter FIRE_PULSE_CYCLES = `FIRE_PULSE_NS / `CLK_PERIOD_NS
) (
   input wire clk,
   input wire rst,
   input wire [NZ-1:0] zone_fault,
   input wire [NZ-1:0] zone_short,
   input wire [NZ-1:0] zone_open,
   input wire [NZ*`ZT_WIDTH-1:0] zone_type,
   input wire [NZ-1:0] zone_bypass,
   input wire [NZ-1:0] zone_perimeter_arm_with_delays,
   input wire [NZ-1:0] day_trouble_report_en,
   input wire [`ARM_WIDTH-1:0] arm_state,
   input wire trouble_ack,
   input wire [DW-1:0] primary_entry_time,
   input wire [DW-1:0] primary_exit_time,
   input wire [DW-1:0] secondary_entry_time,
   input wire [DW-1:0] secondary_exit_time,
   output reg [NZ-1:0] zone_alarm,
   output reg [NZ-1:0] zone_trouble,
   output reg [NZ-1:0] zone_report,
   output reg [NZ-1:0] zone_auto_bypassed,
   output reg fire_alarm,
   output reg entry_delay_active,
   output reg exit_delay_active,
   output reg keypad_sounder,
   output reg bell
);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function [`ZT_WIDTH-1:0] type_of;
      input [NZ*`ZT_WIDTH-1:0] all;
      input integer idx;
      begin
         type_of = all[idx*`ZT_WIDTH +: `ZT_WIDTH];
      end
   endfunction

   // ------------------------------------------------------------------
   // Pin synchronisers: three stages, change accepted when 2 and 3 agree
   // ------------------------------------------------------------------
   reg [NZ-1:0] f_s1, f_s2, f_s3, fault;
   reg [NZ-1:0] s_s1, s_s2, s_s3, shorted;
   reg [NZ-1:0] o_s1, o_s2, o_s3, opened;

   // Stage the pins and update the filtered level on agreement
   always @(posedge clk) begin
      if (rst) begin
         f_s1 <= {NZ{1'b0}}; f_s2 <= {NZ{1'b0}}; f_s3 <= {NZ{1'b0}};
         s_s1 <= {NZ{1'b0}}; s_s2 <= {NZ{1'b0}}; s_s3 <= {NZ{1'b0}};
         o_s1 <= {NZ{1'b0}}; o_s2 <= {NZ{1'b0}}; o_s3 <= {NZ{1'b0}};
         fault <= {NZ{1'b0}};
         shorted <= {NZ{1'b0}};
         opened <= {NZ{1'b0}};
      end else begin
         f_s1 <= zone_fault; f_s2 <= f_s1; f_s3 <= f_s2;
         s_s1 <= zone_short; s_s2 <= s_s1; s_s3 <= s_s2;
         o_s1 <= zone_open; o_s2 <= o_s1; o_s3 <= o_s2;
         fault <= (f_s2 & f_s3) | (fault & (f_s2 | f_s3));
         shorted <= (s_s2 & s_s3) | (shorted & (s_s2 | s_s3));
         opened <= (o_s2 & o_s3) | (opened & (o_s2 | o_s3));
      end
   end

   // ------------------------------------------------------------------
   // Arming state decode
   // ------------------------------------------------------------------
   // One-hot arming code is sampled directly every clock
   wire armed = ~arm_state[`ARM_DISARMED] & (|arm_state);
   wire with_delays = arm_state[`ARM_FULL_DLY] | arm_state[`ARM_PERIM_DLY];
   wire perim_mode = arm_state[`ARM_PERIM_DLY] | arm_state[`ARM_PERIM_NODLY];
   wire full_mode = arm_state[`ARM_FULL_DLY] | arm_state[`ARM_FULL_NODLY];
   reg armed_q;
   wire arm_event = armed & ~armed_q;

   // ------------------------------------------------------------------
   // Delay timers
   // ------------------------------------------------------------------
   reg pri_entry_go, sec_entry_go;
   wire pri_entry_run, pri_entry_exp, sec_entry_run, sec_entry_exp;
   wire pri_exit_run, sec_exit_run;
   reg entry_pending;                 // An entry/exit zone started an entry
   wire exit_run = pri_exit_run | sec_exit_run;

   // Secondary durations are assumed longer than primary ones
   zone_delay_timer #(.W(DW)) u_pri_entry (
      .clk(clk), .rst(rst), .load(pri_entry_go), .abort(~armed),
      .duration(primary_entry_time), .running(pri_entry_run), .expired(pri_entry_exp));
   zone_delay_timer #(.W(DW)) u_sec_entry (
      .clk(clk), .rst(rst), .load(sec_entry_go), .abort(~armed),
      .duration(secondary_entry_time), .running(sec_entry_run), .expired(sec_entry_exp));
   // Exit delays start on every arming event, any mode
   zone_delay_timer #(.W(DW)) u_pri_exit (
      .clk(clk), .rst(rst), .load(arm_event), .abort(~armed),
      .duration(primary_exit_time), .running(pri_exit_run), .expired());
   zone_delay_timer #(.W(DW)) u_sec_exit (
      .clk(clk), .rst(rst), .load(arm_event), .abort(~armed),
      .duration(secondary_exit_time), .running(sec_exit_run), .expired());

   // ------------------------------------------------------------------
   // Per-zone evaluation (combinational)
   // ------------------------------------------------------------------
   reg [NZ-1:0] next_alarm, next_trouble, next_report, next_byp;
   reg [NZ-1:0] pend_pri, pend_sec, pend_fol, next_pend_pri, next_pend_sec, next_pend_fol;
   reg next_keypad, next_bell_steady, next_fire;
   reg [`ZT_WIDTH-1:0] t;
   integer i;

   // Panic, polling and RF zones share this path by type
   always @* begin
      next_alarm = zone_alarm;
      next_trouble = zone_trouble;
      next_report = zone_report;
      next_byp = {NZ{1'b0}};
      next_pend_pri = pend_pri;
      next_pend_sec = pend_sec;
      next_pend_fol = pend_fol;
      next_keypad = 1'b0;
      next_bell_steady = 1'b0;
      next_fire = 1'b0;
      pri_entry_go = 1'b0;
      sec_entry_go = 1'b0;
      t = `ZT_UNUSED;
      for (i = 0; i < NZ; i = i + 1) begin
         t = type_of(zone_type, i);
         if (!armed) begin
            next_pend_pri[i] = 1'b0;
            next_pend_sec[i] = 1'b0;
            next_pend_fol[i] = 1'b0;
         end
         case (t)
            `ZT_UNUSED: begin
               next_alarm[i] = 1'b0;
               next_trouble[i] = 1'b0;
               next_report[i] = 1'b0;
            end
            `ZT_ENTRY_EXIT1: begin
               if (armed && fault[i] && !zone_bypass[i] && !exit_run) begin
                  if (with_delays) begin
                     pri_entry_go = 1'b1;
                     next_pend_pri[i] = 1'b1;
                  end else begin
                     next_alarm[i] = 1'b1;
                  end
               end
               if (pend_pri[i] && pri_entry_exp && armed)
                  next_alarm[i] = 1'b1;
            end
            `ZT_ENTRY_EXIT2: begin
               if (armed && fault[i] && !zone_bypass[i] && !exit_run) begin
                  if (with_delays) begin
                     sec_entry_go = 1'b1;
                     next_pend_sec[i] = 1'b1;
                  end else begin
                     next_alarm[i] = 1'b1;
                  end
               end
               if (pend_sec[i] && sec_entry_exp && armed)
                  next_alarm[i] = 1'b1;
            end
            `ZT_PERIMETER: begin
               if (armed && fault[i] && !zone_bypass[i])
                  next_alarm[i] = 1'b1;
            end
            `ZT_FOLLOWER: begin
               next_byp[i] = armed & perim_mode & zone_perimeter_arm_with_delays[i];
               if (full_mode && fault[i] && !zone_bypass[i] && !exit_run) begin
                  if (arm_state[`ARM_FULL_DLY] && entry_pending)
                     next_pend_fol[i] = 1'b1;
                  else
                     next_alarm[i] = 1'b1;
               end
               if (pend_fol[i] && armed && (pri_entry_exp || sec_entry_exp))
                  next_alarm[i] = 1'b1;
            end
            `ZT_DAY_NIGHT: begin
               if (fault[i] && !zone_bypass[i]) begin
                  if (armed) begin
                     next_alarm[i] = 1'b1;
                  end else begin
                     next_trouble[i] = 1'b1;
                     next_report[i] = day_trouble_report_en[i];
                  end
               end else if (trouble_ack && !armed) begin
                  next_trouble[i] = 1'b0;
               end
               if (zone_trouble[i]) next_keypad = 1'b1;
            end
            `ZT_SILENT_24: begin
               if (fault[i] && !zone_bypass[i])
                  next_report[i] = 1'b1;
            end
            `ZT_AUDIBLE_24: begin
               if (fault[i] && !zone_bypass[i]) begin
                  next_report[i] = 1'b1;
                  next_alarm[i] = 1'b1;
               end
               if (zone_alarm[i]) begin
                  next_keypad = 1'b1;
                  next_bell_steady = 1'b1;
               end
            end
            `ZT_AUX_24: begin
               if (fault[i] && !zone_bypass[i]) begin
                  next_report[i] = 1'b1;
                  next_alarm[i] = 1'b1;
               end
               if (zone_alarm[i]) next_keypad = 1'b1;
            end
            `ZT_FIRE: begin
               if (shorted[i]) begin
                  next_alarm[i] = 1'b1;
                  next_report[i] = 1'b1;
               end
               if (opened[i]) next_trouble[i] = 1'b1;
               else if (trouble_ack) next_trouble[i] = 1'b0;
               if (zone_alarm[i]) next_fire = 1'b1;
               if (zone_trouble[i]) next_keypad = 1'b1;
            end
            default: begin
               next_alarm[i] = 1'b0;
               next_trouble[i] = 1'b0;
               next_report[i] = 1'b0;
            end
         endcase
         // Burglary alarms sound keypad and bell while latched
         if (zone_alarm[i] && (t == `ZT_ENTRY_EXIT1 || t == `ZT_ENTRY_EXIT2 ||
             t == `ZT_PERIMETER || t == `ZT_FOLLOWER || t == `ZT_DAY_NIGHT)) begin
            next_keypad = 1'b1;
            next_bell_steady = 1'b1;
         end
         // Disarming clears burglary alarms; 24-hour and fire need an ack
         // with the cause gone, so a standing fault always wins over the ack
         if (!armed && t >= `ZT_ENTRY_EXIT1 && t <= `ZT_DAY_NIGHT)
            next_alarm[i] = 1'b0;
         if (trouble_ack && !fault[i] && t >= `ZT_SILENT_24 && t <= `ZT_AUX_24)
            next_alarm[i] = 1'b0;
         if (trouble_ack && (t == `ZT_FIRE ? !shorted[i] : !fault[i])) begin
            next_report[i] = 1'b0;
            if (t == `ZT_FIRE) next_alarm[i] = 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Fire bell pulse generator
   // ------------------------------------------------------------------
   reg [31:0] pulse_count;
   reg pulse_phase;

   // Toggle the pulse phase at a fixed period while fire is active
   always @(posedge clk) begin
      if (rst) begin
         pulse_count <= 32'h00000000;
         pulse_phase <= 1'b0;
      end else if (!fire_alarm) begin
         pulse_count <= 32'h00000000;
         pulse_phase <= 1'b1;
      end else if (pulse_count >= FIRE_PULSE_CYCLES - 1) begin
         pulse_count <= 32'h00000000;
         pulse_phase <= ~pulse_phase;
      end else begin
         pulse_count <= pulse_count + 32'h00000001;
      end
   end

   // ------------------------------------------------------------------
   // State and output registers
   // ------------------------------------------------------------------
   // Register all results; outputs come straight from flip-flops
   always @(posedge clk) begin
      if (rst) begin
         armed_q <= 1'b0;
         entry_pending <= 1'b0;
         pend_pri <= {NZ{1'b0}};
         pend_sec <= {NZ{1'b0}};
         pend_fol <= {NZ{1'b0}};
         zone_alarm <= {NZ{1'b0}};
         zone_trouble <= {NZ{1'b0}};
         zone_report <= {NZ{1'b0}};
         zone_auto_bypassed <= {NZ{1'b0}};
         fire_alarm <= 1'b0;
         entry_delay_active <= 1'b0;
         exit_delay_active <= 1'b0;
         keypad_sounder <= 1'b0;
         bell <= 1'b0;
      end else begin
         armed_q <= armed;
         entry_pending <= armed & (pri_entry_go | sec_entry_go | pri_entry_run |
                                   sec_entry_run);
         pend_pri <= next_pend_pri & ~next_alarm;
         pend_sec <= next_pend_sec & ~next_alarm;
         pend_fol <= next_pend_fol & ~next_alarm;
         zone_alarm <= next_alarm;
         zone_trouble <= next_trouble;
         zone_report <= next_report;
         zone_auto_bypassed <= next_byp;
         fire_alarm <= next_fire;
         entry_delay_active <= pri_entry_run | sec_entry_run;
         exit_delay_active <= exit_run;
         keypad_sounder <= next_keypad | next_fire;
         bell <= next_bell_steady | (next_fire & pulse_phase);
      end
   end

endmodule
`default_nettype wire

/* File: verification/zone_response_checker.sv */
// Assertion checker for the zone response evaluator.
// Assumes a bind onto the evaluator; all signals share clk.
`timescale 1ns/10ps
`default_nettype none
`include "zone_response_defines.vh"

module zone_response_checker #(
   parameter NZ = 19,
   parameter FIRE_PULSE_CYCLES = 4
) (
   input wire clk,
   input wire rst,
   input wire [NZ*`ZT_WIDTH-1:0] zone_type,
   input wire [NZ-1:0] zone_perimeter_arm_with_delays,
   input wire [`ARM_WIDTH-1:0] arm_state,
   input wire [NZ-1:0] zone_alarm,
   input wire [NZ-1:0] zone_trouble,
   input wire [NZ-1:0] zone_report,
   input wire [NZ-1:0] zone_auto_bypassed,
   input wire fire_alarm,
   input wire entry_delay_active,
   input wire exit_delay_active,
   input wire keypad_sounder,
   input wire bell
);
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   wire [NZ-1:0] loud;
   wire [NZ-1:0] ring;
   wire [NZ-1:0] aud;
   wire [NZ-1:0] fol;
   wire [NZ-1:0] unused;
   wire quiet;
   reg bell_q;
   reg [31:0] run;
   genvar i;

   // Classes of zones by programmed type; loud, ring and aud only while in alarm
   generate
      for (i = 0; i < NZ; i = i + 1) begin : g_zone
         wire [3:0] t = zone_type[4*i +: 4];
         assign loud[i] = zone_alarm[i] && t != `ZT_SILENT_24;
         assign ring[i] = loud[i] && t != `ZT_AUX_24;
         assign aud[i] = zone_alarm[i] && t == `ZT_AUDIBLE_24;
         assign fol[i] = t == `ZT_FOLLOWER;
         assign unused[i] = t == `ZT_UNUSED;
      end
   endgenerate
   assign quiet = ~|loud && ~|zone_trouble && !fire_alarm && !entry_delay_active
      && !exit_delay_active;

   // Cycles the bell has held one level under a fire alarm
   always @(posedge clk) begin
      bell_q <= bell;
      if (rst || !fire_alarm || bell != bell_q) begin
         run <= 32'h0;
      end else begin
         run <= run + 32'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   unused_zone_quiet_a:
      assert property (((zone_alarm | zone_trouble | zone_report) & unused) == '0)
      else $error("Unused zone raised an output");
   arm_exit_start_a:
      assert property ($past(arm_state[0]) && !arm_state[0] |-> ##[1:3] exit_delay_active)
      else $error("Exit delay did not start on arming");
   entry_mode_a:
      assert property ($rose(entry_delay_active) |-> $past(arm_state[1] | arm_state[2]))
      else $error("Entry delay started in a mode without one");
   disarm_abort_a:
      assert property ($rose(arm_state[0]) |-> ##2 (!entry_delay_active && !exit_delay_active))
      else $error("Delay kept running after disarm");
   perimeter_arm_with_delays_bypass_a:
      assert property ((zone_auto_bypassed & ~(zone_perimeter_arm_with_delays & fol)) == '0)
      else $error("Bypass on a zone without perimeter_arm_with_delays follower setting");
   bypass_silent_a:
      assert property ((zone_auto_bypassed & zone_alarm & ~$past(zone_alarm)) == '0)
      else $error("Bypassed zone raised an alarm");
   fire_pulse_a:
      assert property (fire_alarm |-> run <= FIRE_PULSE_CYCLES + 1)
      else $error("Bell not pulsing under fire alarm");
   silent_zone_a:
      assert property (quiet [*3] |-> !keypad_sounder && !bell)
      else $error("Sounder on with only silent alarms");
   aux_no_bell_a:
      assert property ((~|ring && !fire_alarm) [*3] |-> !bell)
      else $error("Bell on with only keypad alarms");
   audible_zone_a:
      assert property ((|aud && !fire_alarm) [*3] |-> bell && keypad_sounder)
      else $error("Audible alarm without bell and sounder");
endmodule
`default_nettype wire

/* File: verification/zone_field_model.sv */
// Field side model: zone loop contacts and a watcher on the bell.
// Assumes the bench calls its tasks just after a falling clock edge.
`timescale 1ns/10ps
`default_nettype none

module zone_field_model #(
   parameter NZ = 19
) (
   input wire logic clk,
   input wire logic bell,
   output var logic [NZ-1:0] zone_fault,
   output var logic [NZ-1:0] zone_short,
   output var logic [NZ-1:0] zone_open
);
   int toggles = 0;
   logic bell_q = 1'b0;

   // Loops start restored
   initial begin
      zone_fault = '0;
      zone_short = '0;
      zone_open = '0;
   end

   // Sets one loop condition on all zones: 0 fault, 1 short, 2 open
   task drive(input int k, input logic [NZ-1:0] v);
      case (k)
         0: zone_fault = v;
         1: zone_short = v;
         default: zone_open = v;
      endcase
   endtask

   // Restores every loop
   task release_all;
      zone_fault = '0;
      zone_short = '0;
      zone_open = '0;
   endtask

   // Counts bell level changes so pulsing can be seen
   always @(posedge clk) begin
      if (bell !== bell_q) begin
         toggles <= toggles + 1;
      end
      bell_q <= bell;
   end
endmodule
`default_nettype wire

/* File: verification/zone_response_evaluator_tb_top.sv */
// Self-checking bench for the zone response evaluator.
// Assumes 19 zones and a bell half period shortened to 4 cycles.
`timescale 1ns/10ps
`default_nettype none

module zone_response_evaluator_tb_top;
   localparam int NZ = 19;
   localparam int FP = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   wire [NZ-1:0] zone_fault, zone_short, zone_open;
   logic [NZ*4-1:0] zone_type = 76'h3000_7000_4987_6543_210;
   logic [NZ-1:0] zone_bypass = '0;
   logic [NZ-1:0] zone_perimeter_arm_with_delays = 19'h10;
   logic [NZ-1:0] day_trouble_report_en = '0;
   logic [4:0] arm_state = 5'h01;
   logic trouble_ack = 1'b0;
   // Secondary delays longer than primary
   logic [15:0] primary_entry_time = 16'h1E;
   logic [15:0] primary_exit_time = 16'h0C;
   logic [15:0] secondary_entry_time = 16'h32;
   logic [15:0] secondary_exit_time = 16'h18;
   wire [NZ-1:0] zone_alarm, zone_trouble, zone_report, zone_auto_bypassed;
   wire fire_alarm, entry_delay_active, exit_delay_active, keypad_sounder, bell;
   int n_mismatch = 0;
   int comparisons = 0;

   zone_response_evaluator #(.NZ(NZ), .FIRE_PULSE_CYCLES(FP)) dut (
      .clk, .rst, .zone_fault, .zone_short, .zone_open, .zone_type, .zone_bypass,
      .zone_perimeter_arm_with_delays, .day_trouble_report_en, .arm_state, .trouble_ack, .primary_entry_time,
      .primary_exit_time, .secondary_entry_time, .secondary_exit_time, .zone_alarm,
      .zone_trouble, .zone_report, .zone_auto_bypassed, .fire_alarm, .entry_delay_active,
      .exit_delay_active, .keypad_sounder, .bell
   );
   zone_field_model #(.NZ(NZ)) field (.clk, .bell, .zone_fault, .zone_short, .zone_open);

   // 250 MHz clock
   always #2 clk = ~clk;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task chk(input logic [NZ-1:0] got, input logic [NZ-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task done(input string s);
      $display("Test %s finished", s);
   endtask
   // Arms in one mode and lets both exit delays run out
   task arm(input int m);
      arm_state = 5'h01 << m;
      cyc(3);
      chk(exit_delay_active, 1'b1);
      cyc(40);
   endtask
   // Restores loops, disarms and acknowledges
   task idle;
      field.release_all;
      cyc(8);
      arm_state = 5'h01;
      trouble_ack = 1'b1;
      cyc(2);
      trouble_ack = 1'b0;
      cyc(4);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_instant;
      for (int m = 1; m < 5; m++) begin
         arm(m);
         field.drive(0, 19'h40029);
         cyc(8);
         chk(zone_alarm & 19'h40029, 19'h40028);
         idle;
         chk(zone_alarm, '0);
      end
      done("instant");
   endtask
   task t_entry;
      for (int z = 1; z < 3; z++) begin
         for (int m = 1; m < 5; m++) begin
            arm(m);
            field.drive(0, 19'h1 << z);
            cyc(8);
            chk(zone_alarm[z], m > 2);
            chk(entry_delay_active, m < 3);
            cyc(z * 40);
            chk(zone_alarm[z], 1'b1);
            idle;
         end
      end
      done("entry");
   endtask
   task t_abort;
      arm(1);
      field.drive(0, 19'h4);
      cyc(8);
      arm_state = 5'h01;
      cyc(80);
      chk({zone_alarm[2], entry_delay_active}, 2'b00);
      idle;
      done("abort");
   endtask
   task t_follower;
      arm(1);
      field.drive(0, 19'h10);
      cyc(8);
      chk(zone_alarm[4], 1'b1);
      idle;
      for (int m = 1; m < 5; m += 3) begin
         arm(m);
         field.drive(0, 19'h2);
         cyc(8);
         field.drive(0, 19'h12);
         cyc(8);
         chk(zone_alarm[4], m == 4);
         cyc(40);
         chk(zone_alarm[4], 1'b1);
         idle;
      end
      for (int m = 2; m < 4; m++) begin
         zone_perimeter_arm_with_delays = (m == 2) ? 19'h10 : '0;
         arm(m);
         chk(zone_auto_bypassed, zone_perimeter_arm_with_delays);
         field.drive(0, 19'h410);
         cyc(8);
         chk(zone_alarm & 19'h410, '0);
         idle;
      end
      zone_perimeter_arm_with_delays = 19'h10;
      done("follower");
   endtask
   task t_day;
      day_trouble_report_en = 19'h20;
      field.drive(0, 19'h20);
      cyc(8);
      chk({zone_trouble[5], zone_report[5], keypad_sounder, zone_alarm[5]}, 4'hE);
      idle;
      chk(zone_trouble, '0);
      day_trouble_report_en = '0;
      done("day");
   endtask
   task t_24h;
      int zs[4];
      logic [1:0] ex[4];
      zs = '{6, 7, 8, 14};
      ex = '{2'b00, 2'b11, 2'b10, 2'b11};
      for (int k = 0; k < 4; k++) begin
         field.drive(0, 19'h1 << zs[k]);
         cyc(8);
         chk(zone_report[zs[k]], 1'b1);
         chk({keypad_sounder, bell}, ex[k]);
         trouble_ack = 1'b1;
         cyc(2);
         trouble_ack = 1'b0;
         chk({zone_report[zs[k]], zone_alarm[zs[k]]}, {1'b1, ex[k][1]});
         idle;
      end
      done("24h");
   endtask
   task t_fire;
      int n;
      zone_bypass = 19'h200;
      field.drive(1, 19'h200);
      cyc(8);
      chk({fire_alarm, zone_alarm[9], zone_report[9]}, 3'b111);
      n = field.toggles;
      cyc(40);
      chk(field.toggles - n >= 8, 1'b1);
      field.drive(1, '0);
      field.drive(2, 19'h200);
      cyc(8);
      chk(zone_trouble[9], 1'b1);
      idle;
      chk({fire_alarm, zone_report[9]}, 2'b00);
      zone_bypass = '0;
      done("fire");
   endtask

   task finish_test;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      cyc(3);
      rst = 1'b0;
      cyc(1);
      t_instant;
      t_entry;
      t_abort;
      t_follower;
      t_day;
      t_24h;
      t_fire;
      finish_test;
   end
   // Watchdog well beyond the expected run
   initial begin
      #80000;
      $display("ERROR %0t: watchdog expired", $time);
      n_mismatch++;
      finish_test;
   end
endmodule

bind zone_response_evaluator zone_response_checker #(
   .NZ(NZ),
   .FIRE_PULSE_CYCLES(FIRE_PULSE_CYCLES)
) checker_i (
   .clk, .rst, .zone_type, .zone_perimeter_arm_with_delays, .arm_state, .zone_alarm, .zone_trouble,
   .zone_report, .zone_auto_bypassed, .fire_alarm, .entry_delay_active,
   .exit_delay_active, .keypad_sounder, .bell
);
`default_nettype wire
